// ---- hdl/supervisor_release_delay_regs.vh ----
`ifndef SUPERVISOR_RELEASE_DELAY_REGS_VH
`define SUPERVISOR_RELEASE_DELAY_REGS_VH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define BROWNOUT_CONFIG_ADDR     8'h18
`define RELEASE_DELAY_ADDR       8'h19
`define BROWNOUT_CONFIG_RESET    8'hc0
`define RELEASE_DELAY_RESET      8'h80

// ----------------------------------------
// field positions
// ----------------------------------------
`define BO_RESP_MSB      7
`define BO_RESP_LSB      6
`define BO_THR_MSB       5
`define BO_THR_LSB       2
`define BO_HYS_MSB       1
`define BO_HYS_LSB       0
`define RETRY_EN_BIT     7
`define RESERVED_BIT     6
`define WP_DLY_MSB       5
`define WP_DLY_LSB       4
`define RST_DLY_MSB      3
`define RST_DLY_LSB      2
`define POWER_GOOD_RELEASE_DELAY_SEL_MSB       1
`define POWER_GOOD_RELEASE_DELAY_SEL_LSB       0

// ----------------------------------------
// timing: slow tick and delays in slow periods
// ----------------------------------------
`define MCLK_HZ          250000000
`define SLOW_CLK_HZ      31500
`define SLOW_TICK_CYCLES (`MCLK_HZ / `SLOW_CLK_HZ)
`define DLY_31US_TICKS   6'd1
`define DLY_254US_TICKS  6'd8
`define DLY_508US_TICKS  6'd16
`define DLY_1016US_TICKS 6'd32

`endif

// ---- hdl/release_delay_timer.v ----
`timescale 1ns/100ps
// ----------------------------------------
// release delay: assert at once, release after n slow ticks
// ----------------------------------------
module release_delay_timer (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       tick_i,
  input  wire       assert_i,
  input  wire [5:0] ticks_i,
  output reg        pin_asserted_o
);
  reg [5:0] count_reg;

  // assertion is immediate; only the release is stretched
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg      <= 6'h00;
      pin_asserted_o <= 1'b1;
    end else if (assert_i) begin
      count_reg      <= 6'h00;
      pin_asserted_o <= 1'b1;
    end else if (pin_asserted_o && tick_i) begin
      if (count_reg + 6'h01 >= ticks_i) begin
        pin_asserted_o <= 1'b0;
        count_reg      <= 6'h00;
      end else begin
        count_reg <= count_reg + 6'h01;
      end
    end
  end
endmodule

// ---- hdl/supervisor_release_delay_config.v ----
`timescale 1ns/100ps
// Behaviour
// - two-bit response field picks one of four brownout comparator speeds
// - four-bit threshold code: 2.800V at zero, plus 100mV per step to 4.300V
// - two-bit hysteresis code: 150mV at zero, 50mV steps to 300mV
// - retry counter enable bit: 0 off, 1 on
// - write-protect release delay: 00 0us, 10 508us, 11 1016us
// - zero write-protect delay releases it with system reset
// - reset release delay: 00 0us, 01 254us, 10 508us, 11 1016us
// - power-good release delay: 00 31us, 01 254us, 10 508us, 11 1016us
// - timing runs from a 31.5kHz internal tick
`include "supervisor_release_delay_regs.vh"
module supervisor_release_delay_config #(
  parameter TICK_CYCLES = `SLOW_TICK_CYCLES
) (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       pg_internal_asserted_i,
  input  wire       reset_internal_asserted_i,
  input  wire       wp_internal_asserted_i,
  output reg  [7:0] reg_rdata_o,
  output reg  [1:0] brownout_response_select_o,
  output reg  [3:0] brownout_threshold_code_o,
  output reg  [1:0] brownout_hysteresis_code_o,
  output reg  [3:0] brownout_threshold_mv_idx_o,
  output reg        retry_count_en_o,
  output reg        power_good_out_o,
  output reg        power_good_out_oe_o,
  output reg        reset_out_n_o,
  output reg        reset_out_n_oe_o,
  output reg        write_protect_n_o,
  output reg        write_protect_n_oe_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]  brownout_config_reg;
  reg [7:0]  release_delay_reg;
  reg [17:0] tick_count_reg;
  reg        tick_reg;
  reg [2:0]  pg_sync_reg;
  reg [2:0]  rst_sync_reg;
  reg [2:0]  wp_sync_reg;
  wire       pg_held;
  wire       rst_held;
  wire       wp_held;
  wire       rst_src;
  wire       wp_src;
  wire       rst_eff;
  wire       wp_eff;

  // register writes; reserved bit stored but software keeps it zero
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_config_reg <= `BROWNOUT_CONFIG_RESET;
      release_delay_reg   <= `RELEASE_DELAY_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `BROWNOUT_CONFIG_ADDR) begin
        brownout_config_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `RELEASE_DELAY_ADDR) begin
        release_delay_reg <= reg_wdata_i;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `BROWNOUT_CONFIG_ADDR: reg_rdata_o <= brownout_config_reg;
        `RELEASE_DELAY_ADDR:   reg_rdata_o <= release_delay_reg;
        default:               reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // brownout comparator and retry controls
  // ----------------------------------------
  // registered copies so every output comes from a flip-flop
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brownout_response_select_o  <= 2'b11;
      brownout_threshold_code_o   <= 4'h0;
      brownout_hysteresis_code_o  <= 2'b00;
      brownout_threshold_mv_idx_o <= 4'h0;
      retry_count_en_o            <= 1'b1;
    end else begin
      brownout_response_select_o <= brownout_config_reg[`BO_RESP_MSB:`BO_RESP_LSB];
      brownout_threshold_code_o   <= brownout_config_reg[`BO_THR_MSB:`BO_THR_LSB];
      brownout_threshold_mv_idx_o <= brownout_config_reg[`BO_THR_MSB:`BO_THR_LSB];
      brownout_hysteresis_code_o <= brownout_config_reg[`BO_HYS_MSB:`BO_HYS_LSB];
      retry_count_en_o <= release_delay_reg[`RETRY_EN_BIT];
    end
  end

  // ----------------------------------------
  // slow tick and input synchronisers
  // ----------------------------------------
  // 31.5kHz enable pulse from the fast clock
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_count_reg <= 18'h00000;
      tick_reg       <= 1'b0;
    end else if (tick_count_reg == TICK_CYCLES - 1) begin
      tick_count_reg <= 18'h00000;
      tick_reg       <= 1'b1;
    end else begin
      tick_count_reg <= tick_count_reg + 18'h00001;
      tick_reg       <= 1'b0;
    end
  end

  // internal supervisor levels come from another domain; stage 1 feeds stage 2 only
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pg_sync_reg  <= 3'b111;
      rst_sync_reg <= 3'b111;
      wp_sync_reg  <= 3'b111;
    end else begin
      pg_sync_reg  <= {pg_sync_reg[1:0], pg_internal_asserted_i};
      rst_sync_reg <= {rst_sync_reg[1:0], reset_internal_asserted_i};
      wp_sync_reg  <= {wp_sync_reg[1:0], wp_internal_asserted_i};
    end
  end

  // ----------------------------------------
  // delay code decode
  // ----------------------------------------
  function [5:0] ticks_of;
    input [1:0] code;
    input       zero_at_00;
    begin
      // codes map to 1 (0 when zero_at_00 is set), 8, 16, 32 slow periods
      case (code)
        2'b00:   ticks_of = zero_at_00 ? 6'd0 : `DLY_31US_TICKS;
        2'b01:   ticks_of = `DLY_254US_TICKS;
        2'b10:   ticks_of = `DLY_508US_TICKS;
        default: ticks_of = `DLY_1016US_TICKS;
      endcase
    end
  endfunction

  // ----------------------------------------
  // release chain: power-good, then reset, then write protect
  // ----------------------------------------
  // power-good delay, 31us minimum
  release_delay_timer u_pg_timer (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .tick_i         (tick_reg),
    .assert_i       (pg_sync_reg[2]),
    .ticks_i        (ticks_of(release_delay_reg[`POWER_GOOD_RELEASE_DELAY_SEL_MSB:`POWER_GOOD_RELEASE_DELAY_SEL_LSB], 1'b0)),
    .pin_asserted_o (pg_held)
  );

  // zero reset delay follows power-good release; waits on pg too
  assign rst_src = rst_sync_reg[2] | pg_held;

  // reset release delay counts after its internal release
  release_delay_timer u_rst_timer (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .tick_i         (tick_reg),
    .assert_i       (rst_src),
    .ticks_i        (ticks_of(release_delay_reg[`RST_DLY_MSB:`RST_DLY_LSB], 1'b1)),
    .pin_asserted_o (rst_held)
  );

  // code 00 bypasses the timer: a timer would still wait for a slow tick
  assign rst_eff = (release_delay_reg[`RST_DLY_MSB:`RST_DLY_LSB] == 2'b00) ? rst_src : rst_held;

  // write protect waits on the reset as the pin will show it
  assign wp_src = wp_sync_reg[2] | rst_eff;

  // write-protect delay; code 01 gives 254us
  release_delay_timer u_wp_timer (
    .mclk_i         (mclk_i),
    .rst_i          (rst_i),
    .tick_i         (tick_reg),
    .assert_i       (wp_src),
    .ticks_i        (ticks_of(release_delay_reg[`WP_DLY_MSB:`WP_DLY_LSB], 1'b1)),
    .pin_asserted_o (wp_held)
  );

  // code 00 bypasses the timer so write protect tracks reset exactly
  assign wp_eff = (release_delay_reg[`WP_DLY_MSB:`WP_DLY_LSB] == 2'b00) ? wp_src : wp_held;

  // ----------------------------------------
  // open-drain pins: drive low while asserted
  // ----------------------------------------
  // zero-delay codes skip their timer, so same-edge release holds
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      power_good_out_o     <= 1'b0;
      power_good_out_oe_o  <= 1'b1;
      reset_out_n_o        <= 1'b0;
      reset_out_n_oe_o     <= 1'b1;
      write_protect_n_o    <= 1'b0;
      write_protect_n_oe_o <= 1'b1;
    end else begin
      power_good_out_o     <= 1'b0;
      power_good_out_oe_o  <= pg_held;
      reset_out_n_o        <= 1'b0;
      reset_out_n_oe_o     <= rst_eff;
      write_protect_n_o    <= 1'b0;
      write_protect_n_oe_o <= wp_eff;
    end
  end
endmodule

// ---- sim/sup_chk_sva.sv ----
`timescale 1ns/100ps
// ------------------------------
// supervisor port checks
// ------------------------------
module sup_chk #(
  parameter TICK_CYCLES = 4
) (
  input wire       mclk_i,
  input wire       rst_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       pg_internal_asserted_i,
  input wire [1:0] brownout_response_select_o,
  input wire [3:0] brownout_threshold_code_o,
  input wire [1:0] brownout_hysteresis_code_o,
  input wire       retry_count_en_o,
  input wire       power_good_out_oe_o,
  input wire       reset_out_n_oe_o,
  input wire       write_protect_n_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // field copies trail the write edge by two edges
  property p_resp;
    reg_wr_i && reg_addr_i == 8'h18 |-> ##2 brownout_response_select_o == $past(reg_wdata_i[7:6], 2);
  endproperty
  property p_thr;
    reg_wr_i && reg_addr_i == 8'h18 |-> ##2 brownout_threshold_code_o == $past(reg_wdata_i[5:2], 2);
  endproperty
  property p_hys;
    reg_wr_i && reg_addr_i == 8'h18 |-> ##2 brownout_hysteresis_code_o == $past(reg_wdata_i[1:0], 2);
  endproperty
  property p_retry;
    reg_wr_i && reg_addr_i == 8'h19 |-> ##2 retry_count_en_o == $past(reg_wdata_i[7], 2);
  endproperty
  // pin pulls low within a few edges, never released early
  property p_pg_on;
    $rose(pg_internal_asserted_i) |-> ##[1:6] power_good_out_oe_o;
  endproperty
  property p_pg_min;
    $fell(power_good_out_oe_o) |-> !$past(pg_internal_asserted_i, 3);
  endproperty
  // releases are chained, so no pin may overtake its predecessor
  property p_rst_chain;
    $fell(reset_out_n_oe_o) |-> !power_good_out_oe_o;
  endproperty
  property p_wp_chain;
    $fell(write_protect_n_oe_o) |-> !reset_out_n_oe_o;
  endproperty
  a_resp: assert property (p_resp) else $error("response copy wrong");
  a_thr: assert property (p_thr) else $error("threshold copy wrong");
  a_hys: assert property (p_hys) else $error("hysteresis copy wrong");
  a_retry: assert property (p_retry) else $error("retry enable wrong");
  a_pg_on: assert property (p_pg_on) else $error("power good not pulled low");
  a_pg_min: assert property (p_pg_min) else $error("power good released early");
  a_rst_chain: assert property (p_rst_chain) else $error("reset released before power good");
  a_wp_chain: assert property (p_wp_chain) else $error("write protect released before reset");
  c_pg: cover property ($fell(power_good_out_oe_o));
  c_rst: cover property ($fell(reset_out_n_oe_o));
  c_wp: cover property ($fell(write_protect_n_oe_o));
endmodule

bind supervisor_release_delay_config sup_chk #(.TICK_CYCLES(TICK_CYCLES)) i_sup_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .pg_internal_asserted_i(pg_internal_asserted_i), .brownout_response_select_o(brownout_response_select_o),
  .brownout_threshold_code_o(brownout_threshold_code_o), .brownout_hysteresis_code_o(brownout_hysteresis_code_o),
  .retry_count_en_o(retry_count_en_o), .power_good_out_oe_o(power_good_out_oe_o),
  .reset_out_n_oe_o(reset_out_n_oe_o), .write_protect_n_oe_o(write_protect_n_oe_o));

// ---- sim/pin_pullups.sv ----
`timescale 1ns/100ps
// ------------------------------
// board pull-ups on the open-drain pins
// ------------------------------
module pin_pullups (
  input  wire [2:0] oe_i,
  input  wire [2:0] out_i,
  output wire [2:0] pin_o
);
  // released pin floats up to the rail
  assign pin_o = (oe_i & out_i) | ~oe_i;
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`include "supervisor_release_delay_regs.vh"
module tb;
  localparam T = 4;
  reg        mclk_i = 0, rst_i = 1, wr = 0, rd = 0;
  reg  [2:0] intl = 3'b111;
  reg  [7:0] addr = 0, wdata = 0;
  wire [7:0] rdata;
  wire [1:0] resp, hys;
  wire [3:0] thr, mv;
  wire       retry;
  wire [2:0] oe, od, pin;
  int        mismatches = 0, total_checks = 0;
  int        ticks[4] = '{1, 8, 16, 32};

  supervisor_release_delay_config #(.TICK_CYCLES(T)) i_supervisor_release_delay_config (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .pg_internal_asserted_i(intl[0]), .reset_internal_asserted_i(intl[1]), .wp_internal_asserted_i(intl[2]),
    .reg_rdata_o(rdata), .brownout_response_select_o(resp), .brownout_threshold_code_o(thr),
    .brownout_hysteresis_code_o(hys), .brownout_threshold_mv_idx_o(mv), .retry_count_en_o(retry),
    .power_good_out_o(od[0]), .power_good_out_oe_o(oe[0]), .reset_out_n_o(od[1]), .reset_out_n_oe_o(oe[1]),
    .write_protect_n_o(od[2]), .write_protect_n_oe_o(oe[2]));
  pin_pullups i_pin_pullups (.oe_i(oe), .out_i(od), .pin_o(pin));

  initial forever #2 mclk_i = ~mclk_i;

  // ------------------------------
  // shared tasks
  // ------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // fields settle two edges after the write edge
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge mclk_i) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge mclk_i) wr <= 0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    @(posedge mclk_i) begin rd <= 1; addr <= a; end
    @(posedge mclk_i) rd <= 0;
    @(posedge mclk_i) #1 d = rdata;
  endtask
  // first tick may be partial, so allow one tick of slack
  task rng(input int d, input int n);
    chk(n == 0 ? d == 0 : (d >= (n - 1) * T && d <= n * T + 2), 1);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task t_regs;
    reg [7:0] d;
    rd_reg(`BROWNOUT_CONFIG_ADDR, d); chk(d, 8'hc0);
    rd_reg(`RELEASE_DELAY_ADDR, d); chk(d, 8'h80);
    chk({resp, retry}, 8'h07);
    wr_reg(8'h20, 8'hff);
    rd_reg(8'h20, d); chk(d, 8'h00);
    rd_reg(`BROWNOUT_CONFIG_ADDR, d); chk(d, 8'hc0);
  endtask
  task t_fields;
    reg [7:0] d;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`BROWNOUT_CONFIG_ADDR, {i[1:0], 4'(i * 5), i[1:0]});
      chk(resp, i);
      chk(thr, i * 5);
      chk(mv, i * 5);
      chk(hys, i);
      rd_reg(`BROWNOUT_CONFIG_ADDR, d); chk(d, {i[1:0], 4'(i * 5), i[1:0]});
    end
    wr_reg(`RELEASE_DELAY_ADDR, 8'h00); chk(retry, 0);
    wr_reg(`RELEASE_DELAY_ADDR, 8'h80); chk(retry, 1);
  endtask
  task t_delay(input int c);
    int tp, tr, tw;
    tp = -1; tr = -1; tw = -1;
    wr_reg(`RELEASE_DELAY_ADDR, {2'b10, c[1:0], c[1:0], c[1:0]});
    @(posedge mclk_i) intl <= 3'b111;
    repeat (8) @(posedge mclk_i);
    #1 chk(pin, 0);
    @(posedge mclk_i) intl <= 3'b000;
    for (int n = 1; n <= 600 && tw < 0; n++) begin
      @(posedge mclk_i) #1;
      if (tp < 0 && pin[0] === 1'b1) tp = n;
      if (tr < 0 && pin[1] === 1'b1) tr = n;
      if (tw < 0 && pin[2] === 1'b1) tw = n;
    end
    if (tw < 0 || tr < 0 || tp < 0) begin
      mismatches++;
      end_sim;
    end
    chk(tp >= (ticks[c] - 1) * T + 2 && tp <= ticks[c] * T + 6, 1);
    rng(tr - tp, c == 0 ? 0 : ticks[c]);
    rng(tw - tr, c == 0 ? 0 : ticks[c]);
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 0;
    t_regs;
    t_fields;
    for (int c = 0; c < 4; c++) t_delay(c);
    end_sim;
  end
endmodule
